// [design/dbtc_defines.svh]
// Register offsets, reset values and counter constants of the dual byte timer
`ifndef DBTC_DEFINES_SVH
`define DBTC_DEFINES_SVH

`define DBTC_ADDR_CTRL      16'hFE10
`define DBTC_ADDR_PRESCALE  16'hFE11
`define DBTC_ADDR_LOW_CNT   16'hFE12
`define DBTC_ADDR_HIGH_CNT  16'hFE13
`define DBTC_ADDR_LOW_RLD   16'hFE14
`define DBTC_ADDR_HIGH_RLD  16'hFE15
`define DBTC_ADDR_LOW_CAPA  16'hFE16
`define DBTC_ADDR_HIGH_CAPA 16'hFE17
`define DBTC_ADDR_LOW_CAPB  16'hFE1E
`define DBTC_ADDR_HIGH_CAPB 16'hFE1F

`define DBTC_RST_CTRL       8'h00
`define DBTC_RST_PRESCALE   8'h00
`define DBTC_RST_RELOAD     8'h00
`define DBTC_CNT_ZERO       8'h00
`define DBTC_CNT_ONE        8'h01
`define DBTC_CNT_FULL       8'hFF
`define DBTC_GAP_ONE        9'h001
`define DBTC_RD_NONE        8'h00

`endif

// [design/dbtc_pkg.sv]
// Types shared by the dual byte timer/counter
`default_nettype none
package dbtc_pkg;

  typedef logic [7:0]  dbtc_byte_t;
  typedef logic [15:0] dbtc_addr_t;

  // Control register, bit 7 first
  typedef struct packed {
    logic high_byte_run;
    logic low_byte_run;
    logic width_select;
    logic low_clock_select;
    logic high_match_flag;
    logic high_irq_enable;
    logic low_match_flag;
    logic low_irq_enable;
  } dbtc_ctrl_t;

  typedef struct packed {
    dbtc_addr_t addr;
    dbtc_byte_t wdata;
    logic       wr;
    logic       rd;
  } dbtc_bus_req_t;

  // Single-cycle detection strobes on the cycle clock
  typedef struct packed {
    logic ext_count;
    logic cap_a_low;
    logic cap_a_high;
    logic cap_b_low;
    logic cap_b_high;
  } dbtc_events_t;

endpackage

`default_nettype wire

// [design/dbtc_top.sv]
// Dual byte timer/counter with prescaler, match buffers and capture registers
//
// Notes on behaviour
// - High run off: high counter held at zero, its buffer follows high reload.
// - High run on: high counter counts, buffer reloads on each match.
// - Low run off: low counter held at zero, its buffer follows low reload.
// - Low run on: low counter counts, buffer reloads on each match.
// - Width select 0: two independent 8-bit timer/counters.
// - Width select 1: one 16-bit counter, match needs all 16 bits equal.
// - Low clock select: prescaler match when 0, external count strobe when 1.
// - High match flag set on match while high runs, sticky until cleared.
// - High interrupt enable and high flag both set request the high interrupt.
// - Low match flag set on match while low runs, sticky until cleared.
// - Low interrupt enable and low flag both set request the low interrupt.
// - In 16-bit mode both match flags set together on the 16-bit match while high runs.
// - Any prescaler register write restarts the prescaler from zero.
// - Prescaler period is register value plus one cycle clocks.
// - Read-only low counter counts prescaler matches or external strobes.
// - Read-only high counter counts prescaler matches or low counter carries.
// - Two low capture registers take the low counter on their strobes.
// - Two high capture registers take the high counter on their strobes.
// - Each byte counter returns to zero when stopped or on its match.
// - Prescaler matches when its count equals the register, 1 to 256 cycles.
// - Prescaler runs except in low-power standby.
// - High counter clock: prescaler match in 8-bit mode, low carry in 16-bit.
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "dbtc_defines.svh"

module dbtc_top
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire dbtc_pkg::dbtc_bus_req_t bus_req_i,
  input  wire dbtc_pkg::dbtc_events_t  events_i,
  input  wire logic                   standby_i,
  output var  dbtc_pkg::dbtc_byte_t    rdata_o,
  output logic                        irq_low_o,
  output logic                        irq_high_o
);
  import dbtc_pkg::*;

  dbtc_ctrl_t ctrl;
  dbtc_ctrl_t ctrl_written;
  dbtc_ctrl_t next_ctrl;
  dbtc_byte_t prescaler_match_value;
  dbtc_byte_t low_match_reload;
  dbtc_byte_t high_match_reload;
  dbtc_byte_t pre_cnt;
  dbtc_byte_t low_cnt;
  dbtc_byte_t high_cnt;
  dbtc_byte_t low_buf;
  dbtc_byte_t high_buf;
  dbtc_byte_t low_capture_a;
  dbtc_byte_t high_capture_a;
  dbtc_byte_t low_capture_b;
  dbtc_byte_t high_capture_b;
  dbtc_byte_t next_pre_cnt;
  dbtc_byte_t next_low_cnt;
  dbtc_byte_t next_high_cnt;
  dbtc_byte_t next_low_buf;
  dbtc_byte_t next_high_buf;
  dbtc_byte_t rd_value;

  wire logic wr_ctrl;
  wire logic wr_prescale;
  wire logic wr_low_rld;
  wire logic wr_high_rld;
  wire logic pre_tick;
  wire logic long_mode;
  wire logic low_clk;
  wire logic high_clk;
  wire logic low_eq;
  wire logic high_eq;
  wire logic low_carry;
  wire logic low_match;
  wire logic high_match;

  // Write decode; counter and capture offsets have no write path
  assign wr_ctrl     = bus_req_i.wr && (bus_req_i.addr == `DBTC_ADDR_CTRL);
  assign wr_prescale = bus_req_i.wr && (bus_req_i.addr == `DBTC_ADDR_PRESCALE);
  assign wr_low_rld  = bus_req_i.wr && (bus_req_i.addr == `DBTC_ADDR_LOW_RLD);
  assign wr_high_rld = bus_req_i.wr && (bus_req_i.addr == `DBTC_ADDR_HIGH_RLD);

  // Prescaler tick; halted during standby
  assign pre_tick = !standby_i && (pre_cnt == prescaler_match_value);

  assign next_pre_cnt = wr_prescale ? `DBTC_CNT_ZERO :
                        standby_i   ? pre_cnt :
                        pre_tick    ? `DBTC_CNT_ZERO :
                                      pre_cnt + `DBTC_CNT_ONE;

  // Count clock selection
  assign long_mode = ctrl.width_select;
  assign low_clk   = ctrl.low_clock_select ? events_i.ext_count : pre_tick;
  assign low_carry = low_clk && (low_cnt == `DBTC_CNT_FULL);
  assign high_clk  = long_mode ? low_carry : pre_tick;

  // Match detection; 16-bit mode needs both bytes equal
  assign low_eq     = (low_cnt == low_buf);
  assign high_eq    = (high_cnt == high_buf);
  assign low_match  = ctrl.low_byte_run && low_clk && low_eq
                      && (!long_mode || high_eq);
  assign high_match = long_mode ? (low_match && ctrl.high_byte_run)
                                : (ctrl.high_byte_run && pre_tick && high_eq);

  // Counters clear when stopped or on their match
  assign next_low_cnt  = !ctrl.low_byte_run ? `DBTC_CNT_ZERO :
                         low_match          ? `DBTC_CNT_ZERO :
                         low_clk            ? low_cnt + `DBTC_CNT_ONE :
                                              low_cnt;
  assign next_high_cnt = !ctrl.high_byte_run ? `DBTC_CNT_ZERO :
                         high_match          ? `DBTC_CNT_ZERO :
                         high_clk            ? high_cnt + `DBTC_CNT_ONE :
                                               high_cnt;

  // Match buffers track reload while stopped, reload on match while running
  assign next_low_buf  = (!ctrl.low_byte_run || low_match) ? low_match_reload : low_buf;
  assign next_high_buf = (!ctrl.high_byte_run || high_match) ? high_match_reload : high_buf;

  // Control update; a match in the clearing cycle keeps its flag
  assign ctrl_written = wr_ctrl ? dbtc_ctrl_t'(bus_req_i.wdata) : ctrl;

  always_comb
  begin
    next_ctrl = ctrl_written;
    next_ctrl.high_match_flag = ctrl_written.high_match_flag | high_match;
    next_ctrl.low_match_flag  = ctrl_written.low_match_flag | low_match;
  end

  assign irq_high_o = ctrl.high_irq_enable && ctrl.high_match_flag;
  assign irq_low_o  = ctrl.low_irq_enable && ctrl.low_match_flag;

  // Read selection; unmapped offsets read zero
  assign rd_value =
    (bus_req_i.addr == `DBTC_ADDR_CTRL)      ? dbtc_byte_t'(ctrl) :
    (bus_req_i.addr == `DBTC_ADDR_PRESCALE)  ? prescaler_match_value :
    (bus_req_i.addr == `DBTC_ADDR_LOW_CNT)   ? low_cnt :
    (bus_req_i.addr == `DBTC_ADDR_HIGH_CNT)  ? high_cnt :
    (bus_req_i.addr == `DBTC_ADDR_LOW_RLD)   ? low_match_reload :
    (bus_req_i.addr == `DBTC_ADDR_HIGH_RLD)  ? high_match_reload :
    (bus_req_i.addr == `DBTC_ADDR_LOW_CAPA)  ? low_capture_a :
    (bus_req_i.addr == `DBTC_ADDR_HIGH_CAPA) ? high_capture_a :
    (bus_req_i.addr == `DBTC_ADDR_LOW_CAPB)  ? low_capture_b :
    (bus_req_i.addr == `DBTC_ADDR_HIGH_CAPB) ? high_capture_b :
                                               `DBTC_RD_NONE;

  // Software registers
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      ctrl                  <= dbtc_ctrl_t'(`DBTC_RST_CTRL);
      prescaler_match_value <= `DBTC_RST_PRESCALE;
      low_match_reload      <= `DBTC_RST_RELOAD;
      high_match_reload     <= `DBTC_RST_RELOAD;
      rdata_o               <= `DBTC_RD_NONE;
    end
    else
    begin
      ctrl <= next_ctrl;
      if (wr_prescale)
        prescaler_match_value <= bus_req_i.wdata;
      if (wr_low_rld)
        low_match_reload <= bus_req_i.wdata;
      if (wr_high_rld)
        high_match_reload <= bus_req_i.wdata;
      rdata_o <= bus_req_i.rd ? rd_value : `DBTC_RD_NONE;
    end
  end

  // Prescaler, counters and match buffers; a prescaler register write restarts the prescaler count
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pre_cnt  <= `DBTC_CNT_ZERO;
      low_cnt  <= `DBTC_CNT_ZERO;
      high_cnt <= `DBTC_CNT_ZERO;
      low_buf  <= `DBTC_RST_RELOAD;
      high_buf <= `DBTC_RST_RELOAD;
    end
    else
    begin
      pre_cnt  <= next_pre_cnt;
      low_cnt  <= next_low_cnt;
      high_cnt <= next_high_cnt;
      low_buf  <= next_low_buf;
      high_buf <= next_high_buf;
    end
  end

  // Capture registers keep no reset value
  always_ff @(posedge clk_sys_i)
  begin
    if (events_i.cap_a_low)
      low_capture_a <= low_cnt;
    if (events_i.cap_b_low)
      low_capture_b <= low_cnt;
    if (events_i.cap_a_high)
      high_capture_a <= high_cnt;
    if (events_i.cap_b_high)
      high_capture_b <= high_cnt;
  end

  // Checking helpers
  logic [8:0] pre_gap;
  logic       pre_gap_valid;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pre_gap       <= `DBTC_GAP_ONE;
      pre_gap_valid <= 1'b0;
    end
    else
    begin
      pre_gap       <= pre_tick ? `DBTC_GAP_ONE : pre_gap + `DBTC_GAP_ONE;
      pre_gap_valid <= (pre_tick || pre_gap_valid) && !wr_prescale && !standby_i;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  sequence s_high_stopped;
    (!ctrl.high_byte_run && !wr_high_rld)[*2];
  endsequence

  sequence s_low_stopped;
    (!ctrl.low_byte_run && !wr_low_rld)[*2];
  endsequence

  a_high_stop_hold:
    assert property (s_high_stopped |-> (high_cnt == `DBTC_CNT_ZERO)
                     && (high_buf == high_match_reload))
    else $error("high counter not held while stopped");

  a_high_buf_reload:
    assert property (high_match |=> (high_buf == $past(high_match_reload))
                     && (high_cnt == `DBTC_CNT_ZERO))
    else $error("high buffer not reloaded on match");

  a_low_stop_hold:
    assert property (s_low_stopped |-> (low_cnt == `DBTC_CNT_ZERO)
                     && (low_buf == low_match_reload))
    else $error("low counter not held while stopped");

  a_low_buf_reload:
    assert property (low_match |=> (low_buf == $past(low_match_reload))
                     && (low_cnt == `DBTC_CNT_ZERO))
    else $error("low buffer not reloaded on match");

  a_long_both_flags:
    assert property (long_mode && low_match && ctrl.high_byte_run
                     |=> ctrl.low_match_flag && ctrl.high_match_flag)
    else $error("16-bit match did not set both flags");

  a_long_full_match:
    assert property (long_mode && low_match |-> (high_cnt == high_buf))
    else $error("16-bit match with unequal high byte");

  a_high_irq_req:
    assert property (high_match ##1 ctrl.high_irq_enable |-> irq_high_o)
    else $error("high interrupt not requested after match");

  a_low_flag_sticky:
    assert property (ctrl.low_match_flag && !wr_ctrl |=> ctrl.low_match_flag)
    else $error("low flag dropped without a clear");

  a_prr_restart:
    assert property (wr_prescale |=> (pre_cnt == `DBTC_CNT_ZERO))
    else $error("prescaler did not restart on write");

  a_pre_period:
    assert property (pre_tick && pre_gap_valid
                     |-> (pre_gap == ({1'b0, prescaler_match_value} + `DBTC_GAP_ONE)))
    else $error("prescaler period differs from register plus one");

  a_low_capture:
    assert property (events_i.cap_a_low |=> (low_capture_a == $past(low_cnt)))
    else $error("low capture took wrong value");

  a_high_capture:
    assert property (events_i.cap_b_high |=> (high_capture_b == $past(high_cnt)))
    else $error("high capture took wrong value");

  a_high_carry:
    assert property (long_mode && ctrl.high_byte_run && low_carry && !high_match
                     |=> (high_cnt == $past(high_cnt) + `DBTC_CNT_ONE))
    else $error("high counter missed low carry");

  sequence s_low_step;
    ctrl.low_byte_run && low_clk && !low_match;
  endsequence

  sequence s_high_step;
    ctrl.high_byte_run && high_clk && !high_match;
  endsequence

  a_low_count_step:
    assert property (s_low_step |=> (low_cnt == $past(low_cnt) + `DBTC_CNT_ONE))
    else $error("low counter missed a count clock");

  a_low_count_idle:
    assert property (ctrl.low_byte_run && !low_clk |=> $stable(low_cnt))
    else $error("low counter moved without a count clock");

  a_high_count_step:
    assert property (s_high_step |=> (high_cnt == $past(high_cnt) + `DBTC_CNT_ONE))
    else $error("high counter missed a count clock");

  a_high_count_idle:
    assert property (ctrl.high_byte_run && !high_clk && !high_match |=> $stable(high_cnt))
    else $error("high counter moved without a count clock");

  a_ext_counts:
    assert property (ctrl.low_byte_run && ctrl.low_clock_select && events_i.ext_count
                     && !low_match |=> (low_cnt == $past(low_cnt) + `DBTC_CNT_ONE))
    else $error("low counter ignored external strobe");

  a_ext_ignores_tick:
    assert property (ctrl.low_byte_run && ctrl.low_clock_select && !events_i.ext_count
                     |=> $stable(low_cnt))
    else $error("low counter moved without external strobe");

  a_high_short_clock:
    assert property (!long_mode && ctrl.high_byte_run && pre_tick && !high_match
                     |=> (high_cnt == $past(high_cnt) + `DBTC_CNT_ONE))
    else $error("high counter missed prescaler tick in 8-bit mode");

  a_short_independent:
    assert property (!long_mode && ctrl.high_byte_run && pre_tick && (high_cnt == high_buf)
                     |-> high_match)
    else $error("high match in 8-bit mode depended on low byte");

  a_high_flag_set:
    assert property (high_match |=> ctrl.high_match_flag)
    else $error("high flag not set on match");

  a_high_flag_sticky:
    assert property (ctrl.high_match_flag && !wr_ctrl |=> ctrl.high_match_flag)
    else $error("high flag dropped without a clear");

  a_low_flag_set:
    assert property (low_match |=> ctrl.low_match_flag)
    else $error("low flag not set on match");

  a_low_irq_req:
    assert property (low_match ##1 ctrl.low_irq_enable |-> irq_low_o)
    else $error("low interrupt not requested after match");

  a_low_capture_b:
    assert property (events_i.cap_b_low |=> (low_capture_b == $past(low_cnt)))
    else $error("second low capture took wrong value");

  a_high_capture_a:
    assert property (events_i.cap_a_high |=> (high_capture_a == $past(high_cnt)))
    else $error("first high capture took wrong value");

  a_standby_freeze:
    assert property (standby_i && !wr_prescale |=> $stable(pre_cnt))
    else $error("prescaler moved in standby");

  a_pre_count_step:
    assert property (!standby_i && !wr_prescale && !pre_tick
                     |=> (pre_cnt == $past(pre_cnt) + `DBTC_CNT_ONE))
    else $error("prescaler missed a cycle");

  a_pre_wrap:
    assert property (pre_tick && !wr_prescale |=> (pre_cnt == `DBTC_CNT_ZERO))
    else $error("prescaler did not wrap on its match");

  a_cnt_write_ignored:
    assert property (bus_req_i.wr && (bus_req_i.addr == `DBTC_ADDR_LOW_CNT)
                     && !ctrl.low_byte_run |=> (low_cnt == `DBTC_CNT_ZERO))
    else $error("write reached the low counter");

endmodule
`default_nettype wire

// [sim/dbtc_event_src.sv]
// Partner model: detectors that deliver count and capture strobes
`timescale 1ns/10ps
`default_nettype none

module dbtc_event_src
(
  input  wire logic                   clk_sys_i,
  output var  dbtc_pkg::dbtc_events_t events_o
);
  import dbtc_pkg::*;

  initial events_o = '0;

  // Each event is a single-cycle strobe on the cycle clock
  task automatic pulse(input dbtc_events_t m, input int n);
    repeat (n)
    begin
      @(posedge clk_sys_i);
      events_o <= m;
      @(posedge clk_sys_i);
      events_o <= '0;
    end
  endtask
endmodule

`default_nettype wire

// [sim/dbtc_top_tb.sv]
// Self-checking testbench of the dual byte timer/counter
`timescale 1ns/10ps
`default_nettype none
`include "dbtc_defines.svh"

module dbtc_top_tb;
  import dbtc_pkg::*;

  localparam dbtc_events_t EV_EXT  = 5'h10;
  localparam dbtc_events_t EV_CAPA = 5'h0C;
  localparam dbtc_events_t EV_CAPB = 5'h03;
  localparam int           PRE     = 2;
  localparam int           RLD     = 3;

  logic          clk_sys_i;
  logic          reset_i;
  logic          standby_i;
  dbtc_bus_req_t req;
  dbtc_events_t  events;
  dbtc_byte_t    rdata;
  logic          irq_low;
  logic          irq_high;
  int            n_errors;
  int            n_compared;
  int            cyc;
  int            t1;
  int            t2;

  dbtc_top dut
  (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .bus_req_i  (req),
    .events_i   (events),
    .standby_i  (standby_i),
    .rdata_o    (rdata),
    .irq_low_o  (irq_low),
    .irq_high_o (irq_high)
  );

  dbtc_event_src src
  (
    .clk_sys_i (clk_sys_i),
    .events_o  (events)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) cyc <= cyc + 1;

  task automatic chk8(input string nm, input dbtc_byte_t exp, input dbtc_byte_t got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input dbtc_addr_t a, input dbtc_byte_t d);
    @(posedge clk_sys_i);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk_sys_i);
    req.wr    <= 1'b0;
  endtask

  task automatic rd(input dbtc_addr_t a, input dbtc_byte_t exp, input string nm);
    @(posedge clk_sys_i);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_sys_i);
    req.rd   <= 1'b0;
    @(posedge clk_sys_i);
    chk8(nm, exp, rdata);
  endtask

  task automatic wait_rise(output int t);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    while (irq_low !== 1'b1 && k < 200)
    begin
      @(posedge clk_sys_i);
      k++;
    end
    chk8("low irq rise", 8'h01, {7'h00, irq_low});
    t = cyc;
  endtask

  task automatic test_reset();
    rd(`DBTC_ADDR_CTRL, 8'h00, "control");
    rd(`DBTC_ADDR_PRESCALE, 8'h00, "prescaler");
    rd(`DBTC_ADDR_LOW_RLD, 8'h00, "low reload");
    rd(`DBTC_ADDR_HIGH_RLD, 8'h00, "high reload");
    rd(16'hFE18, 8'h00, "unmapped");
    wr(`DBTC_ADDR_LOW_CNT, 8'h55);
    wr(`DBTC_ADDR_HIGH_CNT, 8'hAA);
    rd(`DBTC_ADDR_LOW_CNT, 8'h00, "low count");
    rd(`DBTC_ADDR_HIGH_CNT, 8'h00, "high count");
    $display("test reset done");
  endtask

  task automatic test_prescaler();
    wr(`DBTC_ADDR_LOW_RLD, 8'(RLD));
    wr(`DBTC_ADDR_HIGH_RLD, 8'h05);
    wr(`DBTC_ADDR_PRESCALE, 8'(PRE));
    wr(`DBTC_ADDR_CTRL, 8'hC5);
    wait_rise(t1);
    wr(`DBTC_ADDR_CTRL, 8'hC5);
    wait_rise(t2);
    chk8("low period", 8'((RLD + 1) * (PRE + 1)), 8'(t2 - t1));
    rd(`DBTC_ADDR_CTRL, 8'hCF, "control flags");
    chk8("high irq", 8'h01, {7'h00, irq_high});
    wr(`DBTC_ADDR_CTRL, 8'h00);
    rd(`DBTC_ADDR_LOW_CNT, 8'h00, "low stopped");
    rd(`DBTC_ADDR_HIGH_CNT, 8'h00, "high stopped");
    wr(`DBTC_ADDR_CTRL, 8'h02);
    @(posedge clk_sys_i);
    chk8("low irq masked", 8'h00, {7'h00, irq_low});
    wr(`DBTC_ADDR_CTRL, 8'h03);
    @(posedge clk_sys_i);
    chk8("low irq on", 8'h01, {7'h00, irq_low});
    $display("test prescaler done");
  endtask

  task automatic test_capture();
    wr(`DBTC_ADDR_LOW_RLD, 8'hFF);
    wr(`DBTC_ADDR_CTRL, 8'h50);
    src.pulse(EV_EXT, 5);
    src.pulse(EV_CAPA | EV_CAPB, 1);
    wr(`DBTC_ADDR_LOW_CAPA, 8'h77);
    rd(`DBTC_ADDR_LOW_CAPA, 8'h05, "low cap a");
    rd(`DBTC_ADDR_LOW_CAPB, 8'h05, "low cap b");
    rd(`DBTC_ADDR_HIGH_CAPB, 8'h00, "high cap b");
    rd(`DBTC_ADDR_LOW_CNT, 8'h05, "ext count");
    wr(`DBTC_ADDR_CTRL, 8'h00);
    $display("test capture done");
  endtask

  task automatic test_wide();
    wr(`DBTC_ADDR_LOW_RLD, 8'h01);
    wr(`DBTC_ADDR_HIGH_RLD, 8'h01);
    wr(`DBTC_ADDR_CTRL, 8'hF5);
    src.pulse(EV_EXT, 256);
    src.pulse(EV_CAPA, 1);
    rd(`DBTC_ADDR_HIGH_CAPA, 8'h01, "high cap a");
    rd(`DBTC_ADDR_LOW_CAPA, 8'h00, "low cap a");
    src.pulse(EV_EXT, 1);
    @(posedge clk_sys_i);
    chk8("no early match", 8'h00, {7'h00, irq_low});
    src.pulse(EV_EXT, 1);
    @(posedge clk_sys_i);
    chk8("wide low irq", 8'h01, {7'h00, irq_low});
    chk8("wide high irq", 8'h01, {7'h00, irq_high});
    rd(`DBTC_ADDR_CTRL, 8'hFF, "wide flags");
    rd(`DBTC_ADDR_LOW_CNT, 8'h00, "wide low");
    rd(`DBTC_ADDR_HIGH_CNT, 8'h00, "wide high");
    wr(`DBTC_ADDR_CTRL, 8'h00);
    @(posedge clk_sys_i);
    chk8("irq cleared", 8'h00, {6'h00, irq_high, irq_low});
    $display("test wide done");
  endtask

  task automatic test_hold();
    wr(`DBTC_ADDR_PRESCALE, 8'h00);
    wr(`DBTC_ADDR_LOW_RLD, 8'hFF);
    standby_i <= 1'b1;
    wr(`DBTC_ADDR_CTRL, 8'h40);
    rd(`DBTC_ADDR_LOW_CNT, 8'h00, "standby hold");
    standby_i <= 1'b0;
    rd(`DBTC_ADDR_LOW_CNT, 8'h01, "standby release");
    wr(`DBTC_ADDR_CTRL, 8'h00);
    wr(`DBTC_ADDR_PRESCALE, 8'h01);
    wr(`DBTC_ADDR_LOW_RLD, 8'h03);
    wr(`DBTC_ADDR_HIGH_RLD, 8'h00);
    wr(`DBTC_ADDR_CTRL, 8'hE5);
    wait_rise(t1);
    wr(`DBTC_ADDR_CTRL, 8'hE5);
    wait_rise(t2);
    chk8("wide tick period", 8'h08, 8'(t2 - t1));
    chk8("wide tick high irq", 8'h01, {7'h00, irq_high});
    wr(`DBTC_ADDR_CTRL, 8'h00);
    $display("test hold done");
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (4000) @(posedge clk_sys_i);
    n_errors++;
    wrap_up();
  end

  initial
  begin
    reset_i   = 1'b1;
    standby_i = 1'b0;
    req       = '0;
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    test_reset();
    test_prescaler();
    test_capture();
    test_wide();
    test_hold();
    wrap_up();
  end
endmodule

`default_nettype wire
